/* File: rtl/sfbfe_front_end.v */
`timescale 1ns/100ps
`include "sfbfe_map.vh"
module sfbfe_front_end #(
    parameter CLK_MHZ    = `SFBFE_CLK_MHZ,
    parameter FIFO_DEPTH = `SFBFE_FIFO_DEPTH
) (
    input  wire       clk,
    input  wire       reset,
    input  wire       cs_n_pin,
    input  wire       sclk_pin,
    input  wire       reset_pin_n,
    input  wire       lane_zero_in,
    output wire       lane_zero_out,
    output wire       lane_zero_oe_n,
    input  wire       lane_one_in,
    output wire       lane_one_out,
    output wire       lane_one_oe_n,
    input  wire       lane_two_in,
    output wire       lane_two_out,
    output wire       lane_two_oe_n,
    input  wire       lane_three_in,
    output wire       lane_three_out,
    output wire       lane_three_oe_n,
    input  wire       quad_enable_bit,
    input  wire       hold_reset_sel,
    input  wire       phase_out,
    input  wire       phase_dtr,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    output wire       tx_ready,
    output reg  [7:0] instr_code,
    output reg        instr_valid,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    output wire       four_line_command_mode,
    output wire       frame_active,
    output wire       paused,
    output wire       sw_reset_busy,
    output wire       device_reset
);

////////////////////////////////////////////////////////////////////////////
// Timing counts

localparam integer SWRST_CYC_I  = `SFBFE_T_SWRST_US * CLK_MHZ;
localparam integer RSTMIN_CYC_I =
    (`SFBFE_T_RESET_MIN_NS * CLK_MHZ + 999) / 1000;
localparam [15:0]  SWRST_CYC    = SWRST_CYC_I[15:0];
localparam [15:0]  RSTMIN_CYC   = (RSTMIN_CYC_I < 1) ? 16'h0001 :
                                  RSTMIN_CYC_I[15:0];

////////////////////////////////////////////////////////////////////////////
// Helpers

function [7:0] shift_in;
    input [7:0] sh;
    input [1:0] wid;
    input [3:0] ln;
    begin
        case (wid)
            `SFBFE_W2: shift_in = {sh[5:0], ln[1], ln[0]};
            `SFBFE_W4: shift_in = {sh[3:0], ln[3:0]};
            default:   shift_in = {sh[6:0], ln[0]};
        endcase
    end
endfunction

function [3:0] bits_of;
    input [1:0] wid;
    begin
        case (wid)
            `SFBFE_W2: bits_of = 4'h2;
            `SFBFE_W4: bits_of = 4'h4;
            default:   bits_of = 4'h1;
        endcase
    end
endfunction

// Output lanes from the top bits of the byte; lane one carries single data
function [3:0] drive_of;
    input [7:0] b;
    input [1:0] wid;
    begin
        case (wid)
            `SFBFE_W2: drive_of = {2'h0, b[7], b[6]};
            `SFBFE_W4: drive_of = b[7:4];
            default:   drive_of = {2'h0, b[7], 1'h0};
        endcase
    end
endfunction

function [3:0] oe_n_of;
    input [1:0] wid;
    begin
        case (wid)
            `SFBFE_W2: oe_n_of = 4'hc;
            `SFBFE_W4: oe_n_of = 4'h0;
            default:   oe_n_of = 4'hd;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detection

wire [6:0] pins_raw = {reset_pin_n, sclk_pin, cs_n_pin, lane_three_in,
                       lane_two_in, lane_one_in, lane_zero_in};
wire [6:0] pins_s;

sfbfe_sync #(
    .WIDTH   (7),
    .RST_VAL (`SFBFE_PIN_SYNC_RST)
) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   (pins_raw),
    .dout  (pins_s)
);

wire [3:0] lanes_s     = pins_s[3:0];
wire       cs_n_s      = pins_s[4];
wire       sclk_s      = pins_s[5];
wire       rst_pin_n_s = pins_s[6];

reg        sclk_q;
reg        cs_n_q;

always @(posedge clk) begin
    if (reset) begin
        sclk_q <= 1'b0;
        cs_n_q <= 1'b1;
    end else begin
        sclk_q <= sclk_s;
        cs_n_q <= cs_n_s;
    end
end

wire edge_rise = sclk_s & ~sclk_q;
wire edge_fall = ~sclk_s & sclk_q;
wire cs_fall   = ~cs_n_s & cs_n_q;

////////////////////////////////////////////////////////////////////////////
// Shared pin, hardware reset

wire share_rst   = ~quad_enable_bit & hold_reset_sel & ~lanes_s[3];
wire pause_want  = ~quad_enable_bit & ~hold_reset_sel & ~lanes_s[3];
wire hw_rst_low  = ~rst_pin_n_s | share_rst;
// Commands stop at once; full power-on restore waits for a wide pulse
wire blk_rst     = reset | hw_rst_low;

reg [15:0] rst_low_cnt_q;
wire       hw_full = (rst_low_cnt_q == RSTMIN_CYC);

always @(posedge clk) begin
    if (reset | ~hw_rst_low) begin
        rst_low_cnt_q <= 16'h0000;
    end else if (~hw_full) begin
        rst_low_cnt_q <= rst_low_cnt_q + 16'h0001;
    end
end

////////////////////////////////////////////////////////////////////////////
// Frame shifting

reg  [1:0] st_q;
reg        armed_q;
reg        paused_q;
reg        qpi_q;
reg        rst_en_q;
reg  [7:0] sh_in_q;
reg  [3:0] cnt_q;
reg  [1:0] in_wid_q;
reg  [1:0] out_wid_q;
reg  [7:0] sh_out_q;
reg  [3:0] out_cnt_q;
reg  [3:0] lane_out_q;
reg  [3:0] lane_oe_n_q;
reg [15:0] sw_cnt_q;

wire       sw_busy  = (sw_cnt_q != 16'h0000);
wire       sw_done  = (sw_cnt_q == 16'h0001);
wire       active   = ~cs_n_s & ~paused_q;
wire       in_instr = (st_q == `SFBFE_ST_INSTR);
wire       in_body  = (st_q == `SFBFE_ST_BODY);
wire [1:0] wid_sel  = in_instr ? (qpi_q ? `SFBFE_W4 : `SFBFE_W1)
                               : in_wid_q;
wire       do_in    = active & ((in_instr & edge_rise) |
                      (in_body & ~phase_out &
                       (edge_rise | (phase_dtr & edge_fall))));
wire       do_out   = active & in_body & phase_out &
                      (edge_fall | (phase_dtr & edge_rise));
wire [7:0] sh_nx    = shift_in(sh_in_q, wid_sel, lanes_s);
wire [3:0] cnt_nx   = cnt_q + bits_of(wid_sel);
wire       byte_end = do_in & (cnt_nx == 4'h8);
wire       instr_dn = byte_end & in_instr;

// Decode of the instruction byte as it completes
wire       accept   = instr_dn & ~sw_busy;
wire       quad_cmd = (sh_nx == `SFBFE_OP_QUAD_OUT) |
                      (sh_nx == `SFBFE_OP_QUAD_IO);
wire       honour   = accept & (~quad_cmd | quad_enable_bit);
wire       go_qpi   = accept & (sh_nx == `SFBFE_OP_ENTER_4LINE) &
                      quad_enable_bit;
wire       exit_qpi = accept & (sh_nx == `SFBFE_OP_EXIT_4LINE) & qpi_q;
wire       sw_go    = accept & (sh_nx == `SFBFE_OP_RESET) & rst_en_q;

// Data side FIFO; pops only as the link consumes bytes
wire [7:0] fifo_data;
wire       fifo_valid;
wire       fifo_pop = do_out & (out_cnt_q == 4'h0);

sfbfe_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
) u_fifo (
    .clk       (clk),
    .reset     (blk_rst),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
);

// Underrun drives ones rather than stalling the bus clock
wire [7:0] out_byte = fifo_valid ? fifo_data : 8'hff;

always @(posedge clk) begin
    if (reset | hw_full | sw_done) begin
        qpi_q <= 1'b0;
    end else if (go_qpi) begin
        qpi_q <= 1'b1;
    end else if (exit_qpi) begin
        qpi_q <= 1'b0;
    end
end

always @(posedge clk) begin
    if (blk_rst) begin
        sw_cnt_q <= 16'h0000;
    end else if (sw_go) begin
        sw_cnt_q <= SWRST_CYC;
    end else if (sw_busy) begin
        sw_cnt_q <= sw_cnt_q - 16'h0001;
    end
end

always @(posedge clk) begin
    if (blk_rst) begin
        st_q        <= `SFBFE_ST_IDLE;
        armed_q     <= 1'b0;
        paused_q    <= 1'b0;
        rst_en_q    <= 1'b0;
        sh_in_q     <= 8'h00;
        cnt_q       <= 4'h0;
        in_wid_q    <= `SFBFE_W1;
        out_wid_q   <= `SFBFE_W1;
        sh_out_q    <= 8'h00;
        out_cnt_q   <= 4'h0;
        lane_out_q  <= 4'h0;
        lane_oe_n_q <= `SFBFE_OE_N_RST;
        instr_code  <= 8'h00;
        instr_valid <= 1'b0;
        rx_data     <= 8'h00;
        rx_valid    <= 1'b0;
    end else begin
        instr_valid <= 1'b0;
        rx_valid    <= 1'b0;
        if (cs_n_s) begin
            armed_q     <= 1'b1;
            st_q        <= `SFBFE_ST_IDLE;
            paused_q    <= 1'b0;
            lane_oe_n_q <= `SFBFE_OE_N_RST;
        end else if (st_q == `SFBFE_ST_IDLE) begin
            // Edges are counted from the select fall, so idle level is free
            if (cs_fall & armed_q) begin
                st_q      <= `SFBFE_ST_INSTR;
                sh_in_q   <= 8'h00;
                cnt_q     <= 4'h0;
                out_cnt_q <= 4'h0;
            end
        end else begin
            if (~sclk_s) begin
                paused_q <= pause_want;
            end
            if (do_in) begin
                sh_in_q <= sh_nx;
                cnt_q   <= byte_end ? 4'h0 : cnt_nx;
            end
            if (instr_dn) begin
                instr_code  <= sh_nx;
                instr_valid <= honour;
                st_q        <= honour ? `SFBFE_ST_BODY
                                      : `SFBFE_ST_IGNORE;
                if (accept) begin
                    rst_en_q <= (sh_nx == `SFBFE_OP_RESET_ENABLE);
                end
                if (qpi_q) begin
                    in_wid_q  <= `SFBFE_W4;
                    out_wid_q <= `SFBFE_W4;
                end else begin
                    case (sh_nx)
                        `SFBFE_OP_DUAL_OUT: begin
                            in_wid_q  <= `SFBFE_W1;
                            out_wid_q <= `SFBFE_W2;
                        end
                        `SFBFE_OP_DUAL_IO: begin
                            in_wid_q  <= `SFBFE_W2;
                            out_wid_q <= `SFBFE_W2;
                        end
                        `SFBFE_OP_QUAD_OUT: begin
                            in_wid_q  <= `SFBFE_W1;
                            out_wid_q <= `SFBFE_W4;
                        end
                        `SFBFE_OP_QUAD_IO: begin
                            in_wid_q  <= `SFBFE_W4;
                            out_wid_q <= `SFBFE_W4;
                        end
                        default: begin
                            in_wid_q  <= `SFBFE_W1;
                            out_wid_q <= `SFBFE_W1;
                        end
                    endcase
                end
            end else if (byte_end & in_body) begin
                rx_data  <= sh_nx;
                rx_valid <= 1'b1;
            end
            if (~in_body | ~phase_out) begin
                lane_oe_n_q <= `SFBFE_OE_N_RST;
            end else if (do_out) begin
                lane_oe_n_q <= oe_n_of(out_wid_q);
                if (out_cnt_q == 4'h0) begin
                    lane_out_q <= drive_of(out_byte, out_wid_q);
                    sh_out_q   <= out_byte << bits_of(out_wid_q);
                    out_cnt_q  <= 4'h8 - bits_of(out_wid_q);
                end else begin
                    lane_out_q <= drive_of(sh_out_q, out_wid_q);
                    sh_out_q   <= sh_out_q << bits_of(out_wid_q);
                    out_cnt_q  <= out_cnt_q - bits_of(out_wid_q);
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Pin drive; a pause floats lanes but keeps the drive state for resume

wire [3:0] oe_n_pin = lane_oe_n_q | {4{paused_q}};

assign lane_zero_out          = lane_out_q[0];
assign lane_one_out           = lane_out_q[1];
assign lane_two_out           = lane_out_q[2];
assign lane_three_out         = lane_out_q[3];
assign lane_zero_oe_n         = oe_n_pin[0];
assign lane_one_oe_n          = oe_n_pin[1];
assign lane_two_oe_n          = oe_n_pin[2];
assign lane_three_oe_n        = oe_n_pin[3];
assign four_line_command_mode = qpi_q;
assign frame_active           = (st_q != `SFBFE_ST_IDLE);
assign paused                 = paused_q;
assign sw_reset_busy          = sw_busy;
assign device_reset           = hw_rst_low | sw_busy;

endmodule // sfbfe_front_end

/* File: rtl/sfbfe_map.vh */
`ifndef SFBFE_MAP_VH
`define SFBFE_MAP_VH

// Clock rate of the block clock
`define SFBFE_CLK_MHZ          20

// Instruction codes
`define SFBFE_OP_DUAL_OUT      8'h3b
`define SFBFE_OP_DUAL_IO       8'hbb
`define SFBFE_OP_QUAD_OUT      8'h6b
`define SFBFE_OP_QUAD_IO       8'heb
`define SFBFE_OP_ENTER_4LINE   8'h38
`define SFBFE_OP_EXIT_4LINE    8'hff
`define SFBFE_OP_RESET_ENABLE  8'h66
`define SFBFE_OP_RESET         8'h99

// Timing figures in their own units
`define SFBFE_T_SWRST_US       30
`define SFBFE_T_RESET_MIN_NS   1000

// Lane width codes
`define SFBFE_W1               2'h0
`define SFBFE_W2               2'h1
`define SFBFE_W4               2'h2

// Frame states
`define SFBFE_ST_IDLE          2'h0
`define SFBFE_ST_INSTR         2'h1
`define SFBFE_ST_BODY          2'h2
`define SFBFE_ST_IGNORE        2'h3

// Reset values and buffer depth
`define SFBFE_PIN_SYNC_RST     7'h7f
`define SFBFE_OE_N_RST         4'hf
`define SFBFE_FIFO_DEPTH       4

`endif

/* File: rtl/sfbfe_sync.v */
`timescale 1ns/100ps
module sfbfe_sync #(
    parameter       WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input  wire             clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);

reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] sync_q;

// First stage feeds only the second stage
always @(posedge clk) begin
    if (reset) begin
        meta_q <= RST_VAL;
        sync_q <= RST_VAL;
    end else begin
        meta_q <= din;
        sync_q <= meta_q;
    end
end

assign dout = sync_q;

endmodule // sfbfe_sync

/* File: rtl/sfbfe_fifo.v */
`timescale 1ns/100ps
module sfbfe_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4
) (
    input  wire             clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);

localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW:0]      wr_q;
reg [AW:0]      rd_q;
reg [AW:0]      lvl_q;

wire push = in_valid & in_ready;
wire pop  = out_valid & out_ready;

// Full and empty come from an explicit level, so any depth works
assign in_ready  = (lvl_q != DEPTH[AW:0]);
assign out_valid = (lvl_q != {(AW+1){1'b0}});
assign out_data  = mem[rd_q[AW-1:0]];

always @(posedge clk) begin
    if (push) begin
        mem[wr_q[AW-1:0]] <= in_data;
    end
end

always @(posedge clk) begin
    if (reset) begin
        wr_q  <= {(AW+1){1'b0}};
        rd_q  <= {(AW+1){1'b0}};
        lvl_q <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wr_q <= (wr_q[AW-1:0] == DEPTH[AW-1:0] - 1'b1) ?
                    {(AW+1){1'b0}} : wr_q + 1'b1;
        end
        if (pop) begin
            rd_q <= (rd_q[AW-1:0] == DEPTH[AW-1:0] - 1'b1) ?
                    {(AW+1){1'b0}} : rd_q + 1'b1;
        end
        if (push & ~pop) begin
            lvl_q <= lvl_q + 1'b1;
        end else if (pop & ~push) begin
            lvl_q <= lvl_q - 1'b1;
        end
    end
end

endmodule // sfbfe_fifo

/* File: verif/sfbfe_monitor.sv */
`timescale 1ns/100ps
module sfbfe_monitor #(
    parameter CLK_MHZ    = 20,
    parameter FIFO_DEPTH = 4
) (
    input wire       clk,
    input wire       reset,
    input wire       cs_n_pin,
    input wire       reset_pin_n,
    input wire       quad_enable_bit,
    input wire       lane_zero_oe_n,
    input wire       lane_one_oe_n,
    input wire       lane_two_oe_n,
    input wire       lane_three_oe_n,
    input wire [7:0] instr_code,
    input wire       instr_valid,
    input wire       four_line_command_mode,
    input wire       paused,
    input wire       sw_reset_busy,
    input wire       device_reset
);
    localparam int SWRST = 30 * CLK_MHZ;
    logic [11:0] busy_n;
    logic [7:0]  pin_n;
    // Counters span more cycles than a repetition could unroll
    always @(posedge clk) begin
        busy_n <= (reset || !sw_reset_busy) ? 12'h0 : busy_n + 12'h1;
        pin_n  <= (reset || reset_pin_n) ? 8'h0
                  : pin_n + {7'h0, pin_n != 8'hff};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////
    property p_sel_float;
        cs_n_pin [*6] |-> lane_zero_oe_n && lane_one_oe_n
                          && lane_two_oe_n && lane_three_oe_n;
    endproperty
    a_sel_float: assert property (p_sel_float)
        else $error("lane driven while deselected");
    property p_pause_float;
        paused |-> lane_zero_oe_n && lane_one_oe_n;
    endproperty
    a_pause_float: assert property (p_pause_float)
        else $error("lane driven while paused");
    property p_no_pause_qe;
        quad_enable_bit [*4] |-> !paused;
    endproperty
    a_no_pause_qe: assert property (p_no_pause_qe)
        else $error("pause with quad enable set");
    property p_qpi_qe;
        $rose(four_line_command_mode) |-> quad_enable_bit;
    endproperty
    a_qpi_qe: assert property (p_qpi_qe)
        else $error("four-line mode without quad enable");
    property p_enter;
        instr_valid && instr_code == 8'h38 && quad_enable_bit
            |-> ##[0:2] four_line_command_mode;
    endproperty
    a_enter: assert property (p_enter)
        else $error("enter did not switch mode");
    property p_exit;
        instr_valid && instr_code == 8'hff
            |-> ##[0:2] !four_line_command_mode;
    endproperty
    a_exit: assert property (p_exit)
        else $error("exit did not switch mode");
    property p_busy_quiet;
        sw_reset_busy && $past(sw_reset_busy) |-> !instr_valid;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("instruction taken during reset");
    property p_swrst_len;
        $fell(sw_reset_busy) |-> busy_n >= SWRST && busy_n <= SWRST + 1;
    endproperty
    a_swrst_len: assert property (p_swrst_len)
        else $error("software reset length wrong");
    property p_swrst_mode;
        $fell(sw_reset_busy) |-> ##[0:1] !four_line_command_mode;
    endproperty
    a_swrst_mode: assert property (p_swrst_mode)
        else $error("four-line mode kept after reset");
    property p_pin_reset;
        !reset_pin_n [*4] |-> device_reset && !instr_valid;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("reset pin not obeyed");
    property p_pin_mode;
        pin_n == 8'd26 |-> !four_line_command_mode;
    endproperty
    a_pin_mode: assert property (p_pin_mode)
        else $error("four-line mode kept after pin reset");
    c_instr: cover property (instr_valid);
    c_pause: cover property (paused);
    c_qpi: cover property ($rose(four_line_command_mode));
    c_swrst: cover property ($fell(sw_reset_busy));
endmodule // sfbfe_monitor

bind sfbfe_front_end sfbfe_monitor #(
    .CLK_MHZ(CLK_MHZ), .FIFO_DEPTH(FIFO_DEPTH)) mon (
    .clk(clk), .reset(reset), .cs_n_pin(cs_n_pin),
    .reset_pin_n(reset_pin_n), .quad_enable_bit(quad_enable_bit),
    .lane_zero_oe_n(lane_zero_oe_n), .lane_one_oe_n(lane_one_oe_n),
    .lane_two_oe_n(lane_two_oe_n), .lane_three_oe_n(lane_three_oe_n),
    .instr_code(instr_code), .instr_valid(instr_valid),
    .four_line_command_mode(four_line_command_mode), .paused(paused),
    .sw_reset_busy(sw_reset_busy), .device_reset(device_reset));

/* File: verif/sfbfe_host_model.sv */
`timescale 1ns/100ps
module sfbfe_host_model (
    input  wire       clk,
    input  wire [3:0] lane_in,
    output reg        cs_n,
    output reg        sclk,
    output reg  [3:0] h_en,
    output reg  [3:0] h_val
);
    reg m3;
    int i;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        h_en = 4'h8;
        h_val = 4'h8;
        m3 = 1'b0;
    end
    // Half of the 400 ns bus clock
    task half;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task sel(input logic m);
        m3 = m;
        sclk = m;
        half;
        cs_n = 1'b0;
        half;
    endtask
    task desel;
        sclk = m3;
        half;
        cs_n = 1'b1;
        h_en = 4'h8;
        h_val = 4'h8;
        half;
    endtask
    // Bits change while the clock is low, so setup covers the rise
    task put(input logic [7:0] b, input logic four);
        h_en = four ? 4'hf : 4'h9;
        for (i = 7; i >= 0; i = i - (four ? 4 : 1)) begin
            sclk = 1'b0;
            h_val = four ? b[i -: 4] : {3'h4, b[i]};
            half;
            sclk = 1'b1;
            half;
        end
    endtask
    task get(output logic [7:0] b);
        h_en = 4'h8;
        for (i = 0; i < 8; i++) begin
            sclk = 1'b0;
            half;
            sclk = 1'b1;
            half;
            b = {b[6:0], lane_in[1]};
        end
    endtask
    // Double-edge body: lane zero changes midway, every clock edge samples
    task put2(input logic [7:0] b);
        for (i = 7; i >= 0; i--) begin
            h_val[0] = b[i];
            repeat (2) @(posedge clk);
            #1;
            sclk = ~sclk;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    // Select is left alone, so a pause never drops the frame
    task pins(input logic s, input logic p);
        sclk = s;
        h_val[3] = p;
    endtask
endmodule // sfbfe_host_model

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       rst_pin_n = 1'b1;
    logic       qe = 1'b0;
    logic       hold_sel = 1'b0;
    logic       ph_out = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       tx_valid = 1'b0;
    logic       flt = 1'b0;
    logic       ph_dtr = 1'b0;
    wire        tx_ready, instr_valid, rx_valid, mode4, paused, busy, dev_rst;
    wire        cs_n, sclk;
    wire        act;
    wire  [7:0] instr_code, rx_data;
    wire  [3:0] h_en, h_val, d_out, d_oen, lane_in;
    logic [7:0] exp_q[$];
    logic [7:0] rd_q[$];
    logic [7:0] b;
    logic [7:0] codes [4] = '{8'h3b, 8'hbb, 8'h6b, 8'heb};
    int         bad_count = 0;
    int         comparisons = 0;
    int         k;
    always #25 clk = ~clk;
    always @(posedge clk) flt <= ~flt;
    // Undriven lanes toggle so a stale level never passes for data
    assign lane_in = (~d_oen & d_out) | (d_oen & h_en & h_val)
                   | (d_oen & ~h_en & {4{flt}});
    sfbfe_front_end #(.CLK_MHZ(20), .FIFO_DEPTH(4)) dut (
        .clk(clk), .reset(reset), .cs_n_pin(cs_n), .sclk_pin(sclk),
        .reset_pin_n(rst_pin_n), .lane_zero_in(lane_in[0]),
        .lane_zero_out(d_out[0]), .lane_zero_oe_n(d_oen[0]),
        .lane_one_in(lane_in[1]), .lane_one_out(d_out[1]),
        .lane_one_oe_n(d_oen[1]), .lane_two_in(lane_in[2]),
        .lane_two_out(d_out[2]), .lane_two_oe_n(d_oen[2]),
        .lane_three_in(lane_in[3]), .lane_three_out(d_out[3]),
        .lane_three_oe_n(d_oen[3]), .quad_enable_bit(qe),
        .hold_reset_sel(hold_sel), .phase_out(ph_out), .phase_dtr(ph_dtr),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .instr_code(instr_code), .instr_valid(instr_valid),
        .rx_data(rx_data), .rx_valid(rx_valid),
        .four_line_command_mode(mode4), .frame_active(act),
        .paused(paused), .sw_reset_busy(busy), .device_reset(dev_rst));
    sfbfe_host_model host (.clk(clk), .lane_in(lane_in), .cs_n(cs_n),
        .sclk(sclk), .h_en(h_en), .h_val(h_val));
    ////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask
    task conclude;
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task frame(input logic [7:0] c, input logic m3, input logic four);
        host.sel(m3);
        host.put(c, four);
        host.desel;
    endtask
    function logic [7:0] next_exp();
        return exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
    endfunction
    always @(posedge clk)
        if (instr_valid === 1'b1 || rx_valid === 1'b1)
            chk(instr_valid ? instr_code : rx_data, next_exp());
    initial begin
        wait_clk(20000);
        bad_count++;
        conclude;
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        b = $urandom(97);
        wait_clk(2);
        reset = 1'b0;
        wait_clk(4);
        chk(mode4, 8'h00);
        chk(d_oen, 8'h0f);
        for (k = 0; k < 4; k++) begin
            if (k < 2) exp_q.push_back(codes[k]);
            frame(codes[k], k[0], 1'b0);
        end
        b = $urandom;
        exp_q.push_back(8'h3b);
        exp_q.push_back(b);
        host.sel(1'b0);
        host.put(8'h3b, 1'b0);
        host.put(b, 1'b0);
        host.desel;
        // Falls in the instruction must be ignored, then both edges count
        ph_dtr = 1'b1;
        b = $urandom;
        exp_q.push_back(8'h3b);
        exp_q.push_back(b);
        host.sel(1'b0);
        host.put(8'h3b, 1'b0);
        host.put2(b);
        host.desel;
        ph_dtr = 1'b0;
        exp_q.push_back(8'h38);
        frame(8'h38, 1'b0, 1'b0);
        chk(mode4, 8'h00);
        // Fill the buffer past full, then read past empty
        // Codes outside the decoded set read back on one line
        exp_q.push_back(8'h5a);
        host.sel(1'b0);
        host.put(8'h5a, 1'b0);
        tx_valid = 1'b1;
        for (k = 0; k < 5; k++) begin
            tx_data = $urandom;
            chk(tx_ready, k < 4);
            if (k < 4) rd_q.push_back(tx_data);
            wait_clk(1);
        end
        tx_valid = 1'b0;
        rd_q.push_back(8'hff);
        ph_out = 1'b1;
        for (k = 0; k < 5; k++) begin
            host.get(b);
            chk(b, rd_q.pop_front());
        end
        ph_out = 1'b0;
        host.desel;
        exp_q.push_back(8'h3b);
        host.sel(1'b0);
        host.put(8'h3b, 1'b0);
        host.pins(1'b1, 1'b0);
        wait_clk(6);
        chk(paused, 8'h00);
        host.pins(1'b0, 1'b0);
        wait_clk(6);
        chk(paused, 8'h01);
        chk(d_oen, 8'h0f);
        chk(act, 8'h01);
        host.pins(1'b1, 1'b1);
        wait_clk(6);
        chk(paused, 8'h01);
        host.pins(1'b0, 1'b1);
        wait_clk(6);
        chk(paused, 8'h00);
        host.desel;
        chk(act, 8'h00);
        qe = 1'b1;
        exp_q.push_back(8'h6b);
        frame(8'h6b, 1'b1, 1'b0);
        exp_q.push_back(8'h38);
        frame(8'h38, 1'b0, 1'b0);
        chk(mode4, 8'h01);
        exp_q.push_back(8'h66);
        exp_q.push_back(8'h99);
        frame(8'h66, 1'b0, 1'b1);
        frame(8'h99, 1'b0, 1'b1);
        chk(busy, 8'h01);
        frame(8'h3b, 1'b0, 1'b1);
        wait_clk(620);
        chk(busy, 8'h00);
        chk(mode4, 8'h00);
        exp_q.push_back(8'h38);
        exp_q.push_back(8'hff);
        frame(8'h38, 1'b0, 1'b0);
        frame(8'hff, 1'b0, 1'b1);
        chk(mode4, 8'h00);
        exp_q.push_back(8'h38);
        frame(8'h38, 1'b0, 1'b0);
        rst_pin_n = 1'b0;
        wait_clk(30);
        chk(dev_rst, 8'h01);
        chk(mode4, 8'h00);
        rst_pin_n = 1'b1;
        qe = 1'b0;
        hold_sel = 1'b1;
        host.pins(1'b0, 1'b0);
        wait_clk(30);
        chk(dev_rst, 8'h01);
        qe = 1'b1;
        wait_clk(6);
        chk(dev_rst, 8'h00);
        host.pins(1'b0, 1'b1);
        wait_clk(10);
        chk(exp_q.size(), 8'h00);
        conclude;
    end
endmodule // tb
